//--- hw/asp_baud.sv
module asp_baud
	import asp_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [15:0] divisor,
	output logic             tick
);

	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} asp_baud_state_t;

	asp_baud_state_t r_reg;
	asp_baud_state_t r_next;

	// ****************************************
	// divider: one tick every divisor clocks
	// ****************************************
	always_comb
	begin
		r_next = r_reg;
		r_next.tick = 1'b0;
		if (r_reg.cnt == 16'h0000)
		begin
			r_next.tick = 1'b1;
			// zero behaves as one, so the tick never stops
			r_next.cnt = (divisor <= 16'h0001) ? 16'h0000 : divisor - 16'h0001;
		end
		else
			r_next.cnt = r_reg.cnt - 16'h0001;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			r_reg <= '0;
		else if (ce)
			r_reg <= r_next;
	end

	assign tick = r_reg.tick;

endmodule

//--- hw/asp_pkg.sv
package asp_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam int unsigned ADDR_W       = 8;
	localparam logic [7:0]  OFF_TX_DATA  = 8'h00;
	localparam logic [7:0]  OFF_RX_DATA  = 8'h04;
	localparam logic [7:0]  OFF_STATUS0  = 8'h08;
	localparam logic [7:0]  OFF_CTRL0    = 8'h0c;
	localparam logic [7:0]  OFF_CTRL1    = 8'h10;
	localparam logic [7:0]  OFF_DIV_HI   = 8'h14;
	localparam logic [7:0]  OFF_DIV_LO   = 8'h18;
	localparam logic [7:0]  OFF_ADDR_CMP = 8'h1c;
	localparam logic [7:0]  OFF_STATUS1  = 8'h20;

	// ****************************************
	// field positions
	// ****************************************
	localparam int unsigned ST0_RX_AVAIL  = 0;
	localparam int unsigned ST0_TX_EMPTY  = 1;
	localparam int unsigned ST0_PERR      = 2;
	localparam int unsigned ST0_FERR      = 3;
	localparam int unsigned ST0_OVR       = 4;
	localparam int unsigned ST0_BRK       = 5;
	localparam int unsigned ST0_TX_BUSY   = 6;
	localparam int unsigned ST0_CTS       = 7;
	localparam int unsigned C0_TX_EN      = 0;
	localparam int unsigned C0_RX_EN      = 1;
	localparam int unsigned C0_PAR_EN     = 2;
	localparam int unsigned C0_PAR_ODD    = 3;
	localparam int unsigned C0_TWO_STOP   = 4;
	localparam int unsigned C0_CTS_EN     = 5;
	localparam int unsigned C1_MD_EN      = 0;
	localparam int unsigned C1_MPMD_LO    = 1;
	localparam int unsigned C1_MPMD_HI    = 2;
	localparam int unsigned C1_ADDR_MARK  = 3;
	localparam int unsigned C1_TIMER      = 4;
	localparam int unsigned S1_RX_NINTH   = 0;
	localparam int unsigned S1_TIMER_FLAG = 1;

	// ****************************************
	// reset values, timing, answers
	// ****************************************
	localparam logic [15:0] DIV_RESET    = 16'h0001;
	localparam logic [7:0]  ADDR_RESET   = 8'h00;
	localparam logic [3:0]  OVS_MID      = 4'h7;
	localparam logic [3:0]  OVS_LAST     = 4'hf;
	localparam logic [2:0]  LAST_BIT     = 3'h7;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	localparam logic [1:0]  MPMD_ALL     = 2'h0;
	localparam logic [1:0]  MPMD_ADDR    = 2'h1;
	localparam logic [1:0]  MPMD_MATCH   = 2'h2;
	localparam logic [1:0]  MPMD_DATA    = 2'h3;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic       tx_enable;
		logic       rx_enable;
		logic       parity_enable;
		logic       parity_odd;
		logic       two_stop;
		logic       cts_flow_enable;
		logic       multidrop_enable;
		logic [1:0] mpmd;
		logic       tx_address_marker;
		logic       timer_mode;
	} asp_cfg_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       ninth;
		logic       perr;
		logic       ferr;
		logic       brk;
	} asp_rx_result_t;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b010,
		TX_NINTH = 3'b011,
		TX_STOP1 = 3'b100,
		TX_STOP2 = 3'b101
	} asp_tx_state_t;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_NINTH = 3'b011,
		RX_STOP  = 3'b100
	} asp_rx_state_t;

	function automatic logic asp_parity(input logic [7:0] d, input logic odd);
		asp_parity = (^d) ^ odd;
	endfunction

endpackage

//--- hw/asp_rx.sv
module asp_rx
	import asp_pkg::*;
(
	input  wire logic     aclk,
	input  wire logic     aresetn,
	input  wire logic     ce,
	input  wire logic     tick,
	input  wire logic     enable,
	input  wire asp_cfg_t cfg,
	input  wire logic     rxd,
	output asp_rx_result_t result
);

	typedef struct packed {
		asp_rx_state_t  st;
		logic [3:0]     ovs;
		logic [2:0]     bit_cnt;
		logic [7:0]     shift;
		logic           ninth;
		asp_rx_result_t res;
	} asp_rx_reg_t;

	asp_rx_reg_t r_reg;
	asp_rx_reg_t r_next;
	logic        has_ninth;

	// ****************************************
	// 16x oversampled receiver
	// ****************************************
	always_comb
	begin
		has_ninth = cfg.parity_enable | cfg.multidrop_enable;
		r_next = r_reg;
		r_next.res.valid = 1'b0;
		if (tick)
		begin
			r_next.ovs = r_reg.ovs + 4'h1;
			case (r_reg.st)
				RX_IDLE:
				begin
					r_next.ovs = 4'h0;
					if (enable && !rxd)
						r_next.st = RX_START;
				end
				RX_START:
					if (r_reg.ovs == OVS_MID)
					begin
						// a glitch shorter than half a bit is not a start bit
						r_next.st = rxd ? RX_IDLE : RX_DATA;
						r_next.ovs = 4'h0;
						r_next.bit_cnt = 3'h0;
					end
				RX_DATA:
					if (r_reg.ovs == OVS_LAST)
					begin
						r_next.shift = {rxd, r_reg.shift[7:1]};
						r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
						if (r_reg.bit_cnt == LAST_BIT)
							r_next.st = has_ninth ? RX_NINTH : RX_STOP;
					end
				RX_NINTH:
					if (r_reg.ovs == OVS_LAST)
					begin
						r_next.ninth = rxd;
						r_next.st = RX_STOP;
					end
				RX_STOP:
					if (r_reg.ovs == OVS_LAST)
					begin
						// only the first stop bit is checked; a second one reads as idle
						r_next.st = RX_IDLE;
						r_next.res.valid = 1'b1;
						r_next.res.data = r_reg.shift;
						r_next.res.ninth = cfg.multidrop_enable & r_reg.ninth;
						r_next.res.ferr = ~rxd;
						r_next.res.brk = ~rxd & (r_reg.shift == 8'h00) & ~(has_ninth & r_reg.ninth);
						r_next.res.perr = cfg.parity_enable & ~cfg.multidrop_enable
							& (r_reg.ninth != asp_parity(r_reg.shift, cfg.parity_odd));
					end
				default:
					r_next.st = RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			r_reg <= '0;
		else if (ce)
			r_reg <= r_next;
	end

	assign result = r_reg.res;

endmodule

//--- hw/asp_top.sv
// How it works
// - eight data bits, least significant first
// - every character opens with low start
// - one or two high stop bits, selectable
// - parity inserted on transmit, checked on receive
// - shared divider and format, independent engines
// - separate enables; transmit only when enabled
// - transmit-empty flag shows holding register free
// - written byte moves to shifter by itself
// - transmit interrupt while transmit enabled and holding register empty
// - separate transmit and receive interrupt outputs
// - framing, parity, overrun, break reported
// - flow enable decides whether clear-to-send gates
// - multidrop enable selects ninth-bit, four schemes
// - ninth bit from address-marker control bit
// - 16-bit divider as high, low bytes
// - divider also usable as plain timer
// - driver-enable output for external transceiver
// - clear-to-send sampled before start; character finishes
// - ninth bit sits between data and stop
// - receive-available flag shows unread byte
//
// The address map and register access over AXI4-Lite are this design's own decisions.
module asp_top
	import asp_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        rxd,
	input  wire logic        cts_n,
	output logic             txd,
	output logic             line_driver_enable,
	output logic             tx_irq,
	output logic             rx_irq,
	output logic             timer_irq
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic          awready;
		logic          aw_have;
		logic [7:0]    awaddr;
		logic          wready;
		logic          w_have;
		logic [31:0]   wdata;
		logic [3:0]    wstrb;
		logic          bvalid;
		logic [1:0]    bresp;
		logic          arready;
		logic          rvalid;
		logic [31:0]   rdata;
		logic [1:0]    rresp;
		asp_cfg_t      cfg;
		logic [7:0]    div_hi;
		logic [7:0]    div_lo;
		logic [7:0]    addr_cmp;
		logic [7:0]    tx_hold;
		logic          hold_full;
		logic [7:0]    rx_data;
		logic          rx_ninth;
		logic          rx_avail;
		logic          in_frame;
		logic          perr;
		logic          ferr;
		logic          ovr;
		logic          brk;
		logic          timer_flag;
		asp_tx_state_t tx_st;
		logic [3:0]    tx_ovs;
		logic [2:0]    tx_bit;
		logic [7:0]    tx_shift;
		logic          tx_ninth;
		logic          tx_has9;
		logic          txd;
		logic          de;
		logic          tx_irq;
		logic          rx_irq;
		logic          timer_irq;
	} asp_top_state_t;

	asp_top_state_t r_reg;
	asp_top_state_t r_next;
	logic           baud_tick;
	logic           line_tick;
	asp_rx_result_t rx_res;
	logic           addr_byte;
	logic           addr_match;
	logic           accept;
	logic           bit_end;
	logic [7:0]     rd_addr;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == OFF_TX_DATA) || (a == OFF_RX_DATA) || (a == OFF_STATUS0) ||
			(a == OFF_CTRL0) || (a == OFF_CTRL1) || (a == OFF_DIV_HI) ||
			(a == OFF_DIV_LO) || (a == OFF_ADDR_CMP) || (a == OFF_STATUS1);
	endfunction

	// ****************************************
	// shared bit timing and receiver
	// ****************************************
	asp_baud u_baud (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.divisor ({r_reg.div_hi, r_reg.div_lo}),
		.tick    (baud_tick)
	);

	// in timer mode the divider belongs to the timer and the line engines freeze
	assign line_tick = baud_tick & ~r_reg.cfg.timer_mode;

	asp_rx u_rx (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.tick    (line_tick),
		.enable  (r_reg.cfg.rx_enable),
		.cfg     (r_reg.cfg),
		.rxd     (rxd),
		.result  (rx_res)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		r_next = r_reg;
		rd_addr = s_axi_araddr;

		// write channel: address and data taken in either order
		if (s_axi_awvalid && r_reg.awready)
		begin
			r_next.aw_have = 1'b1;
			r_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r_reg.wready)
		begin
			r_next.w_have = 1'b1;
			r_next.wdata = s_axi_wdata;
			r_next.wstrb = s_axi_wstrb;
		end
		if (r_reg.bvalid && s_axi_bready)
			r_next.bvalid = 1'b0;
		if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid)
		begin
			r_next.aw_have = 1'b0;
			r_next.w_have = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = is_mapped(r_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (r_reg.wstrb[0])
			begin
				case (r_reg.awaddr)
					OFF_TX_DATA:
						// a byte written while the holding register is full is dropped
						if (!r_reg.hold_full)
						begin
							r_next.tx_hold = r_reg.wdata[7:0];
							r_next.hold_full = 1'b1;
						end
					OFF_CTRL0:
					begin
						r_next.cfg.tx_enable = r_reg.wdata[C0_TX_EN];
						r_next.cfg.rx_enable = r_reg.wdata[C0_RX_EN];
						r_next.cfg.parity_enable = r_reg.wdata[C0_PAR_EN];
						r_next.cfg.parity_odd = r_reg.wdata[C0_PAR_ODD];
						r_next.cfg.two_stop = r_reg.wdata[C0_TWO_STOP];
						r_next.cfg.cts_flow_enable = r_reg.wdata[C0_CTS_EN];
					end
					OFF_CTRL1:
					begin
						r_next.cfg.multidrop_enable = r_reg.wdata[C1_MD_EN];
						r_next.cfg.mpmd = r_reg.wdata[C1_MPMD_HI:C1_MPMD_LO];
						r_next.cfg.tx_address_marker = r_reg.wdata[C1_ADDR_MARK];
						r_next.cfg.timer_mode = r_reg.wdata[C1_TIMER];
					end
					OFF_DIV_HI:
						r_next.div_hi = r_reg.wdata[7:0];
					OFF_DIV_LO:
						r_next.div_lo = r_reg.wdata[7:0];
					OFF_ADDR_CMP:
						r_next.addr_cmp = r_reg.wdata[7:0];
					default:
						r_next.bresp = r_next.bresp;
				endcase
			end
		end
		r_next.awready = ~r_next.aw_have;
		r_next.wready = ~r_next.w_have;

		// read channel: side effects of reads are the clears
		if (r_reg.rvalid && s_axi_rready)
			r_next.rvalid = 1'b0;
		if (s_axi_arvalid && r_reg.arready)
		begin
			r_next.rvalid = 1'b1;
			r_next.rresp = is_mapped(rd_addr) ? RESP_OKAY : RESP_SLVERR;
			r_next.rdata = 32'h0000_0000;
			case (rd_addr)
				OFF_RX_DATA:
				begin
					r_next.rdata[7:0] = r_reg.rx_data;
					r_next.rx_avail = 1'b0;
				end
				OFF_STATUS0:
				begin
					r_next.rdata[ST0_RX_AVAIL] = r_reg.rx_avail;
					r_next.rdata[ST0_TX_EMPTY] = ~r_reg.hold_full;
					r_next.rdata[ST0_PERR] = r_reg.perr;
					r_next.rdata[ST0_FERR] = r_reg.ferr;
					r_next.rdata[ST0_OVR] = r_reg.ovr;
					r_next.rdata[ST0_BRK] = r_reg.brk;
					r_next.rdata[ST0_TX_BUSY] = r_reg.tx_st != TX_IDLE;
					r_next.rdata[ST0_CTS] = ~cts_n;
					r_next.perr = 1'b0;
					r_next.ferr = 1'b0;
					r_next.ovr = 1'b0;
					r_next.brk = 1'b0;
				end
				OFF_CTRL0:
				begin
					r_next.rdata[C0_TX_EN] = r_reg.cfg.tx_enable;
					r_next.rdata[C0_RX_EN] = r_reg.cfg.rx_enable;
					r_next.rdata[C0_PAR_EN] = r_reg.cfg.parity_enable;
					r_next.rdata[C0_PAR_ODD] = r_reg.cfg.parity_odd;
					r_next.rdata[C0_TWO_STOP] = r_reg.cfg.two_stop;
					r_next.rdata[C0_CTS_EN] = r_reg.cfg.cts_flow_enable;
				end
				OFF_CTRL1:
				begin
					r_next.rdata[C1_MD_EN] = r_reg.cfg.multidrop_enable;
					r_next.rdata[C1_MPMD_HI:C1_MPMD_LO] = r_reg.cfg.mpmd;
					r_next.rdata[C1_ADDR_MARK] = r_reg.cfg.tx_address_marker;
					r_next.rdata[C1_TIMER] = r_reg.cfg.timer_mode;
				end
				OFF_DIV_HI:
					r_next.rdata[7:0] = r_reg.div_hi;
				OFF_DIV_LO:
					r_next.rdata[7:0] = r_reg.div_lo;
				OFF_ADDR_CMP:
					r_next.rdata[7:0] = r_reg.addr_cmp;
				OFF_STATUS1:
				begin
					r_next.rdata[S1_RX_NINTH] = r_reg.rx_ninth;
					r_next.rdata[S1_TIMER_FLAG] = r_reg.timer_flag;
					r_next.timer_flag = 1'b0;
				end
				default:
					r_next.rdata = 32'h0000_0000;
			endcase
		end
		r_next.arready = ~r_next.rvalid;

		// timer: hardware set wins over the read clear
		if (baud_tick && r_reg.cfg.timer_mode)
			r_next.timer_flag = 1'b1;

		// receive acceptance and multidrop filtering
		addr_byte = r_reg.cfg.multidrop_enable & rx_res.ninth;
		addr_match = rx_res.data == r_reg.addr_cmp;
		accept = 1'b1;
		if (r_reg.cfg.multidrop_enable)
		begin
			case (r_reg.cfg.mpmd)
				MPMD_ALL:
					accept = 1'b1;
				MPMD_ADDR:
					accept = addr_byte;
				MPMD_MATCH:
					accept = addr_byte ? addr_match : r_reg.in_frame;
				MPMD_DATA:
					accept = ~addr_byte & r_reg.in_frame;
				default:
					accept = 1'b1;
			endcase
		end
		if (rx_res.valid)
		begin
			if (addr_byte)
				r_next.in_frame = addr_match;
			// errors are reported even for bytes that the filter drops
			r_next.perr = r_next.perr | rx_res.perr;
			r_next.ferr = r_next.ferr | rx_res.ferr;
			r_next.brk = r_next.brk | rx_res.brk;
			if (accept)
			begin
				r_next.ovr = r_next.ovr | r_next.rx_avail;
				r_next.rx_data = rx_res.data;
				r_next.rx_ninth = rx_res.ninth;
				r_next.rx_avail = 1'b1;
			end
		end

		// transmitter
		bit_end = line_tick && (r_reg.tx_ovs == OVS_LAST);
		if (line_tick)
			r_next.tx_ovs = r_reg.tx_ovs + 4'h1;
		case (r_reg.tx_st)
			TX_IDLE:
			begin
				r_next.tx_ovs = 4'h0;
				r_next.txd = 1'b1;
				r_next.de = 1'b0;
				// clear-to-send is looked at here, the clock before the start bit
				if (r_reg.hold_full && r_reg.cfg.tx_enable && !r_reg.cfg.timer_mode &&
					(!r_reg.cfg.cts_flow_enable || !cts_n))
				begin
					r_next.tx_st = TX_START;
					r_next.tx_shift = r_reg.tx_hold;
					r_next.hold_full = 1'b0;
					r_next.tx_has9 = r_reg.cfg.multidrop_enable | r_reg.cfg.parity_enable;
					r_next.tx_ninth = r_reg.cfg.multidrop_enable ? r_reg.cfg.tx_address_marker
						: asp_parity(r_reg.tx_hold, r_reg.cfg.parity_odd);
					r_next.txd = 1'b0;
					r_next.de = 1'b1;
				end
			end
			TX_START:
				if (bit_end)
				begin
					r_next.tx_st = TX_DATA;
					r_next.tx_bit = 3'h0;
					r_next.txd = r_reg.tx_shift[0];
				end
			TX_DATA:
				if (bit_end)
				begin
					r_next.tx_shift = {1'b0, r_reg.tx_shift[7:1]};
					r_next.tx_bit = r_reg.tx_bit + 3'h1;
					r_next.txd = r_reg.tx_shift[1];
					if (r_reg.tx_bit == LAST_BIT)
					begin
						r_next.tx_st = r_reg.tx_has9 ? TX_NINTH : TX_STOP1;
						r_next.txd = r_reg.tx_has9 ? r_reg.tx_ninth : 1'b1;
					end
				end
			TX_NINTH:
				if (bit_end)
				begin
					r_next.tx_st = TX_STOP1;
					r_next.txd = 1'b1;
				end
			TX_STOP1:
				if (bit_end)
				begin
					r_next.tx_st = r_reg.cfg.two_stop ? TX_STOP2 : TX_IDLE;
					r_next.de = r_reg.cfg.two_stop;
				end
			TX_STOP2:
				if (bit_end)
				begin
					r_next.tx_st = TX_IDLE;
					r_next.de = 1'b0;
				end
			default:
				r_next.tx_st = TX_IDLE;
		endcase

		// interrupt request levels, one per engine and one for the timer
		r_next.tx_irq = r_reg.cfg.tx_enable & ~r_next.hold_full;
		r_next.rx_irq = r_next.rx_avail | r_next.perr | r_next.ferr | r_next.ovr | r_next.brk;
		r_next.timer_irq = r_next.timer_flag;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r_reg <= '0;
			r_reg.div_lo <= DIV_RESET[7:0];
			r_reg.div_hi <= DIV_RESET[15:8];
			r_reg.addr_cmp <= ADDR_RESET;
			r_reg.txd <= 1'b1;
		end
		else if (ce)
			r_reg <= r_next;
	end

	assign s_axi_awready = r_reg.awready;
	assign s_axi_wready = r_reg.wready;
	assign s_axi_bresp = r_reg.bresp;
	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_arready = r_reg.arready;
	assign s_axi_rdata = r_reg.rdata;
	assign s_axi_rresp = r_reg.rresp;
	assign s_axi_rvalid = r_reg.rvalid;
	assign txd = r_reg.txd;
	assign line_driver_enable = r_reg.de;
	assign tx_irq = r_reg.tx_irq;
	assign rx_irq = r_reg.rx_irq;
	assign timer_irq = r_reg.timer_irq;

endmodule

//--- test/asp_asserts.sv
// ****************************************
// line and register bus checks
// ****************************************
module asp_asserts (
	input logic aclk,
	input logic aresetn,
	input logic txd,
	input logic line_driver_enable,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_idle; !line_driver_enable |-> txd; endproperty
	property p_start; $rose(line_driver_enable) |-> !txd [*8]; endproperty
	property p_de_on; $rose(line_driver_enable) |-> $fell(txd); endproperty
	// at least half of the last stop bit must have been high
	property p_stop; $fell(line_driver_enable) |-> $past(txd) && $past(txd, 8); endproperty
	property p_b_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
	property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
	property p_ar_off; s_axi_rvalid |-> !s_axi_arready; endproperty

	a_idle: assert property (p_idle) else $error("line low while idle");
	a_start: assert property (p_start) else $error("start bit too short");
	a_de_on: assert property (p_de_on) else $error("driver enable not with start");
	a_stop: assert property (p_stop) else $error("stop bit not high");
	a_b_lat: assert property (p_b_lat) else $error("write response late");
	a_b_done: assert property (p_b_done) else $error("write response stuck");
	a_r_lat: assert property (p_r_lat) else $error("read data late");
	a_r_done: assert property (p_r_done) else $error("read data stuck");
	a_ar_off: assert property (p_ar_off) else $error("read address taken early");

	c_char: cover property ($rose(line_driver_enable));
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind asp_top asp_asserts i_chk (.*);

//--- test/asp_node.sv
// ****************************************
// remote node: drives rxd, decodes txd
// ****************************************
module asp_node #(
	parameter int BT = 16
) (
	input  logic aclk,
	input  logic txd,
	output logic rxd,
	output logic cts_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] seen;
	int         cnt;

	// mid-bit sampling tolerates a start bit one tick off
	initial
	begin
		rxd   = 1'b1;
		cts_n = 1'b0;
		cnt   = 0;
		seen  = '0;
		forever
		begin
			@(negedge txd);
			repeat (BT / 2) @(posedge aclk);
			for (int i = 0; i < 9; i++)
			begin
				repeat (BT) @(posedge aclk);
				seen[i] = txd;
			end
			cnt++;
		end
	end

	task automatic send(input logic [7:0] d, input logic use9, input logic b9);
		@(posedge aclk);
		rxd <= 1'b0;
		repeat (BT) @(posedge aclk);
		for (int i = 0; i < 8; i++)
		begin
			rxd <= d[i];
			repeat (BT) @(posedge aclk);
		end
		if (use9)
		begin
			rxd <= b9;
			repeat (BT) @(posedge aclk);
		end
		rxd <= 1'b1;
		repeat (BT) @(posedge aclk);
	endtask

	// only called between characters
	task automatic hold(input logic v);
		@(posedge aclk);
		cts_n <= v;
	endtask
endmodule

//--- test/test_async_serial_port.sv
module test_async_serial_port
	import asp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        aclk, aresetn, ce, rxd, cts_n, txd;
	logic        line_driver_enable, tx_irq, rx_irq, timer_irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	int          errors, cmp_count;

	asp_top i_dut (.*);
	asp_node i_node (.*);

	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end
		while (s_axi_bvalid !== 1'b1 && n < 100);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 100) errors++;
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end
		while (s_axi_rvalid !== 1'b1 && n < 100);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 100) errors++;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rv, exp);
	endtask

	task automatic wait_tx(input int c);
		for (int i = 0; i < 4000 && i_node.cnt != c; i++) @(posedge aclk);
		if (i_node.cnt != c) errors++;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		rdchk(OFF_STATUS0, 32'h82);
		rdchk(OFF_CTRL0, 32'h00);
		rd(8'h24);
		chk(32'(rr), 32'(RESP_SLVERR));
		chk(rv, 32'h0);
		wr(8'h24, 32'h0);
		chk(32'(rr), 32'(RESP_SLVERR));
		chk(32'(tx_irq), 32'h0);
		// divider reloads only at the end of a count: low byte first keeps that load short
		wr(OFF_DIV_LO, 32'h34);
		wr(OFF_DIV_HI, 32'h12);
		rdchk(OFF_DIV_HI, 32'h12);
		rdchk(OFF_DIV_LO, 32'h34);
		wr(OFF_DIV_HI, 32'h00);
		wr(OFF_DIV_LO, 32'h01);
		$display("reset test done");
	endtask

	task automatic t_cts();
		i_node.hold(1'b1);
		wr(OFF_CTRL0, 32'h21);
		repeat (2) @(posedge aclk);
		chk(32'(tx_irq), 32'h1);
		wr(OFF_TX_DATA, 32'h3c);
		repeat (40) @(posedge aclk);
		rdchk(OFF_STATUS0, 32'h00);
		chk(32'(tx_irq), 32'h0);
		chk(i_node.cnt, 0);
		i_node.hold(1'b0);
		wait_tx(1);
		chk(32'(i_node.seen), 32'h13c);
		chk(32'(tx_irq), 32'h1);
		$display("flow control test done");
	endtask

	task automatic t_par();
		i_node.hold(1'b1);
		for (int k = 0; k < 2; k++)
		begin
			wr(OFF_CTRL0, k ? 32'h1d : 32'h05);
			wr(OFF_TX_DATA, 32'h96);
			wait_tx(2 + k);
			chk(32'(i_node.seen), 32'({k[0], 8'h96}));
		end
		$display("parity test done");
	endtask

	task automatic t_md();
		wr(OFF_CTRL0, 32'h01);
		for (int k = 0; k < 2; k++)
		begin
			wr(OFF_CTRL1, k ? 32'h01 : 32'h09);
			wr(OFF_TX_DATA, 32'h5a);
			wait_tx(4 + k);
			chk(32'(i_node.seen), 32'({~k[0], 8'h5a}));
		end
		wr(OFF_CTRL1, 32'h00);
		$display("ninth bit test done");
	endtask

	task automatic t_rx();
		wr(OFF_CTRL0, 32'h03);
		i_node.send(8'hc3, 1'b0, 1'b0);
		repeat (4) @(posedge aclk);
		chk(32'(rx_irq), 32'h1);
		rdchk(OFF_STATUS0, 32'h03);
		rdchk(OFF_RX_DATA, 32'hc3);
		rdchk(OFF_STATUS0, 32'h02);
		i_node.send(8'h11, 1'b0, 1'b0);
		i_node.send(8'h22, 1'b0, 1'b0);
		repeat (4) @(posedge aclk);
		rdchk(OFF_STATUS0, 32'h13);
		rdchk(OFF_RX_DATA, 32'h22);
		i_node.send(8'h00, 1'b1, 1'b0);
		repeat (4) @(posedge aclk);
		rd(OFF_STATUS0);
		chk(rv & 32'h3c, 32'h28);
		rd(OFF_STATUS0);
		chk(rv & 32'h3c, 32'h00);
		// address bytes only: the data byte after the address must be dropped
		wr(OFF_CTRL1, 32'h03);
		i_node.send(8'h55, 1'b1, 1'b1);
		i_node.send(8'h44, 1'b1, 1'b0);
		repeat (4) @(posedge aclk);
		rdchk(OFF_STATUS1, 32'h01);
		rdchk(OFF_RX_DATA, 32'h55);
		wr(OFF_CTRL1, 32'h00);
		$display("receive test done");
	endtask

	task automatic t_timer();
		wr(OFF_CTRL1, 32'h10);
		repeat (20) @(posedge aclk);
		chk(32'(timer_irq), 32'h1);
		rd(OFF_STATUS1);
		chk(rv & 32'h2, 32'h2);
		wr(OFF_CTRL1, 32'h00);
		$display("timer test done");
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial
	begin
		repeat (20000) @(posedge aclk);
		errors++;
		report_and_stop();
	end

	initial
	begin
		errors = 0;
		cmp_count = 0;
		ce = 1'b1;
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_cts();
		t_par();
		t_md();
		t_rx();
		t_timer();
		report_and_stop();
	end
endmodule
